// ---- hdl/lfc_pkg.sv ----
// Constants for the loop output fault and write-policy register block
// Contract
// R1: Policy bit clear: a write loads its register when chip select rises.
// R2: Policy bit set: writes wait pending until a commit command arrives.
// R3: Output code is a 16-bit unsigned binary value, bit 15 most significant.
// R4: Reset loads output code with low or high default chosen by strap pin.
// R5: Retry interval is (field bits 10:8 plus one) times 50 ms, reset 100 ms.
// R6: Retry interval is ignored when loop mask or retry disable is set.
// R7: Retry enabled: loop fault output returns to code once per interval.
// R8: Retry disabled: code returns only after a status read.
// R9: Loop mask clear: a loop fault drives the low fault level.
// R10: Loop mask set: the code current is kept despite a loop fault.
// R11: Pin disable clear: a loop fault pulls the fault output low.
// R12: Timeout output mask clear: timeout drives the strap-selected fault level; code also requires report mask clear.
// R13: Timeout output mask set: a timeout leaves the output current alone.
// R14: Every write restarts the inactivity timer; expiry reports a timeout.
// R15: A no-operation write restarts the timer and changes nothing else.
// R16: Timeout is (field bits 3:1 plus one) times 50 ms, reset 100 ms.
// R17: Report mask clear: timeout pulls fault output low; set suppresses it.
// R18: A frame is 24 bits, MSB first: 8-bit command then 16 data bits.
// R19: Master commits by writing 0x00FF to address 0x01 after guarded writes.
// R20: Fault level is the code's upper byte with the lower byte forced zero.
// R21: Both timers count 50 ms ticks and restart when their field is rewritten.
// R22: Loop fault input is synchronised to the internal clock before use.
package lfc_pkg;
    localparam int          FRAME_BITS         = 24;
    localparam logic [7:0]  OFS_COMMIT         = 8'h01;
    localparam logic [7:0]  OFS_NOP            = 8'h02;
    localparam logic [7:0]  OFS_WRITE_POLICY   = 8'h03;
    localparam logic [7:0]  OFS_OUTPUT_CODE    = 8'h04;
    localparam logic [7:0]  OFS_FAULT_CONFIG   = 8'h05;
    localparam logic [6:0]  OFS_STATUS         = 7'h09;
    localparam logic [6:0]  OFS_STATUS_ALT     = 7'h7F;
    localparam int          CMD_READ_BIT       = 7;
    localparam logic [15:0] COMMIT_KEY         = 16'h00FF;
    localparam logic        RST_WRITE_POLICY   = 1'b0;
    localparam logic [15:0] RST_FAULT_CONFIG   = 16'h0102;
    localparam logic [15:0] FAULT_CONFIG_MASK  = 16'h07FF;
    localparam logic [15:0] CODE_DEFAULT_LOW   = 16'h2400;
    localparam logic [15:0] CODE_DEFAULT_HIGH  = 16'hE800;
    localparam logic [7:0]  FAULT_LEVEL_LOW    = 8'h24;
    localparam logic [7:0]  FAULT_LEVEL_HIGH   = 8'hE8;
    localparam logic [7:0]  FAULT_LOW_BYTE     = 8'h00;
    localparam int          PROTECT_BIT        = 0;
    localparam int          RETRY_LSB          = 8;
    localparam int          RETRY_MSB          = 10;
    localparam int          RETRY_DIS_BIT      = 7;
    localparam int          LOOP_MASK_BIT      = 6;
    localparam int          LOOP_PIN_DIS_BIT   = 5;
    localparam int          TOUT_OUT_MASK_BIT  = 4;
    localparam int          TOUT_MSB           = 3;
    localparam int          TOUT_LSB           = 1;
    localparam int          TOUT_REPORT_BIT    = 0;
    localparam logic [1:0]  STRAP_SETTLE       = 2'h3;
    localparam int          TICK_MS            = 50;
    localparam int          CLK_PERIOD_NS      = 10;
    localparam int          TICK_CYCLES        = TICK_MS * 1000000 / CLK_PERIOD_NS;
endpackage : lfc_pkg

// ---- hdl/lfc_top.sv ----
// Serial-programmed loop output register bank with fault and timeout handling
`timescale 1ns/100ps
`default_nettype none
module lfc_top
    import lfc_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        sclk_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe_o,
    input  wire logic        fault_level_select_pin_i,
    input  wire logic        loop_fault_i,
    output logic [15:0]      dac_code_o,
    output logic             fault_out_n_o
);

    function automatic logic [3:0] lfc_limit(input logic [2:0] field);
        lfc_limit = {1'b0, field} + 4'h1;
    endfunction : lfc_limit

    function automatic logic [15:0] lfc_fault_code(input logic [7:0] level);
        lfc_fault_code = {level, FAULT_LOW_BYTE};
    endfunction : lfc_fault_code

    // Reset release
    logic rst_q1;
    logic rst_n;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // Link side, runs only while the master clocks a frame
    logic [23:0] shreg;
    logic [4:0]  bit_cnt;
    logic [3:0]  word_cnt;
    always_ff @(posedge sclk_i or negedge rst_n) begin
        if (!rst_n) begin
            shreg    <= 24'h000000;
            bit_cnt  <= 5'h00;
            word_cnt <= 4'h0;
        end else if (!chip_select_n_i) begin
            shreg <= {shreg[22:0], sdi_i}; // [R18]
            if (bit_cnt == 5'(FRAME_BITS - 1)) begin
                bit_cnt  <= 5'h00;
                word_cnt <= word_cnt + 4'h1;
            end else begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // Loopback of the shift register contents
    assign sdo_o    = shreg[23];
    assign sdo_oe_o = !chip_select_n_i;

    a_frame_shift: assert property (@(posedge sclk_i) disable iff (!rst_n) // [R18]
        !chip_select_n_i |=> shreg[0] == $past(sdi_i))
        else $error("serial shift lost a data bit");

    // Pin synchronisers
    logic cs_s1, cs_s2, cs_s3;
    logic strap_s1, strap_s2;
    logic loop_s1, loop_flt;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_s1    <= 1'b1;
            cs_s2    <= 1'b1;
            cs_s3    <= 1'b1;
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            loop_s1  <= 1'b0;
            loop_flt <= 1'b0;
        end else begin
            cs_s1    <= chip_select_n_i;
            cs_s2    <= cs_s1;
            cs_s3    <= cs_s2;
            strap_s1 <= fault_level_select_pin_i;
            strap_s2 <= strap_s1;
            loop_s1  <= loop_fault_i;
            loop_flt <= loop_s1; // [R22]
        end
    end

    // Frame end: link counters are still once chip select is high
    logic       frame_end;
    logic       frame_ok;
    logic [4:0] bit_snap;
    logic [3:0] word_snap;
    assign frame_end = cs_s2 && !cs_s3;
    // Whole multiple of 24 edges since the last frame end
    assign frame_ok  = frame_end && (bit_cnt == bit_snap) && (word_cnt != word_snap); // [R18]

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            bit_snap  <= 5'h00;
            word_snap <= 4'h0;
        end else if (frame_end) begin
            bit_snap  <= bit_cnt;
            word_snap <= word_cnt;
        end
    end

    logic [7:0]  cmd;
    logic [15:0] wdata;
    logic        is_write;
    logic        is_commit;
    logic        status_rd;
    assign cmd       = shreg[23:16];
    assign wdata     = shreg[15:0];
    assign is_write  = frame_ok && !cmd[CMD_READ_BIT];
    assign is_commit = is_write && (cmd == OFS_COMMIT) && (wdata == COMMIT_KEY);
    assign status_rd = frame_ok && cmd[CMD_READ_BIT]
                       && ((cmd[6:0] == OFS_STATUS) || (cmd[6:0] == OFS_STATUS_ALT));

    // Register state
    logic        protect;
    logic [15:0] output_code;
    logic [15:0] fault_config;
    logic        pend_valid;
    logic [7:0]  pend_addr;
    logic [15:0] pend_data;

    // Write path: direct or through the pending slot
    logic        ld_en;
    logic [7:0]  ld_addr;
    logic [15:0] ld_data;
    always_comb begin
        ld_en   = 1'b0;
        ld_addr = cmd;
        ld_data = wdata;
        if (is_write && !protect && (cmd != OFS_COMMIT)) begin
            ld_en = 1'b1; // [R1]
        end else if (is_commit && protect && pend_valid) begin
            ld_en   = 1'b1; // [R2]
            ld_addr = pend_addr;
            ld_data = pend_data;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pend_valid <= 1'b0;
            pend_addr  <= 8'h00;
            pend_data  <= 16'h0000;
        end else if (is_commit) begin
            pend_valid <= 1'b0;
        end else if (is_write && protect && (cmd != OFS_NOP)) begin
            pend_valid <= 1'b1; // [R2]
            pend_addr  <= cmd;
            pend_data  <= wdata;
        end
    end

    logic cfg_ld;
    assign cfg_ld = ld_en && (ld_addr == OFS_FAULT_CONFIG);

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            protect      <= RST_WRITE_POLICY;
            fault_config <= RST_FAULT_CONFIG;
        end else if (ld_en && (ld_addr == OFS_WRITE_POLICY)) begin
            protect <= ld_data[PROTECT_BIT];
        end else if (cfg_ld) begin
            fault_config <= ld_data & FAULT_CONFIG_MASK;
        end
    end

    // Strap is caught once the synchroniser has settled after release
    logic [1:0] boot_cnt;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            boot_cnt    <= 2'h0;
            output_code <= CODE_DEFAULT_LOW;
        end else if (boot_cnt != STRAP_SETTLE) begin
            boot_cnt <= boot_cnt + 2'h1;
            if (boot_cnt == STRAP_SETTLE - 2'h1) begin
                output_code <= strap_s2 ? CODE_DEFAULT_HIGH : CODE_DEFAULT_LOW; // [R4]
            end
        end else if (ld_en && (ld_addr == OFS_OUTPUT_CODE)) begin
            output_code <= ld_data; // [R3]
        end
    end

    logic       retry_dis, loop_mask, pin_dis, tout_out_mask, tout_rpt_mask;
    logic [2:0] retry_field, tout_field;
    assign retry_dis     = fault_config[RETRY_DIS_BIT];
    assign loop_mask     = fault_config[LOOP_MASK_BIT];
    assign pin_dis       = fault_config[LOOP_PIN_DIS_BIT];
    assign tout_out_mask = fault_config[TOUT_OUT_MASK_BIT];
    assign tout_rpt_mask = fault_config[TOUT_REPORT_BIT];
    assign retry_field   = fault_config[RETRY_MSB:RETRY_LSB];
    assign tout_field    = fault_config[TOUT_MSB:TOUT_LSB];

    // Inactivity timer; a write in the expiry cycle restarts it
    logic [31:0] tout_cyc;
    logic [3:0]  tout_ticks;
    logic        tout;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            tout_cyc   <= 32'h00000000;
            tout_ticks <= 4'h0;
            tout       <= 1'b0;
        end else if (is_write || cfg_ld) begin
            tout_cyc   <= 32'h00000000; // [R14] [R15] [R21]
            tout_ticks <= 4'h0;
            tout       <= 1'b0;
        end else if (!tout) begin
            if (tout_cyc == 32'(TICK_CYC - 1)) begin
                tout_cyc   <= 32'h00000000;
                tout_ticks <= tout_ticks + 4'h1;
                if (tout_ticks + 4'h1 == lfc_limit(tout_field)) begin
                    tout <= 1'b1; // [R16]
                end
            end else begin
                tout_cyc <= tout_cyc + 32'h00000001;
            end
        end
    end

    // Retry timer, only live while a loop fault holds the output
    logic        loop_hold;
    logic        retry_run;
    logic        retry_fire;
    logic [31:0] retry_cyc;
    logic [3:0]  retry_ticks;
    assign retry_run  = loop_hold && !retry_dis && !loop_mask; // [R6]
    assign retry_fire = retry_run && (retry_cyc == 32'(TICK_CYC - 1))
                        && (retry_ticks + 4'h1 == lfc_limit(retry_field)); // [R5]

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            retry_cyc   <= 32'h00000000;
            retry_ticks <= 4'h0;
        end else if (!retry_run || cfg_ld || retry_fire) begin
            retry_cyc   <= 32'h00000000; // [R21]
            retry_ticks <= 4'h0;
        end else if (retry_cyc == 32'(TICK_CYC - 1)) begin
            retry_cyc   <= 32'h00000000;
            retry_ticks <= retry_ticks + 4'h1;
        end else begin
            retry_cyc <= retry_cyc + 32'h00000001;
        end
    end

    // Release wins for one cycle so the code is actually retried
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            loop_hold <= 1'b0;
        end else if (loop_mask) begin
            loop_hold <= 1'b0; // [R10]
        end else if (retry_fire) begin
            loop_hold <= 1'b0; // [R7]
        end else if (retry_dis && status_rd) begin
            loop_hold <= 1'b0; // [R8]
        end else if (loop_flt) begin
            loop_hold <= 1'b1; // [R9]
        end
    end

    logic tout_ovr;
    assign tout_ovr = tout && !tout_rpt_mask && !tout_out_mask; // [R12] [R13]

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            dac_code_o    <= CODE_DEFAULT_LOW;
            fault_out_n_o <= 1'b1;
        end else begin
            if (tout_ovr) begin
                dac_code_o <= lfc_fault_code(strap_s2 ? FAULT_LEVEL_HIGH
                                                      : FAULT_LEVEL_LOW); // [R12] [R20]
            end else if (loop_hold) begin
                dac_code_o <= lfc_fault_code(FAULT_LEVEL_LOW); // [R9] [R20]
            end else begin
                dac_code_o <= output_code; // [R3]
            end
            fault_out_n_o <= !((loop_flt && !pin_dis) || (tout && !tout_rpt_mask)); // [R11] [R17]
        end
    end

    // System clock domain checks; the link check above carries its own clock
    a_direct_load: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R1]
        (ld_en && !protect && is_write && cmd == OFS_OUTPUT_CODE && boot_cnt == STRAP_SETTLE)
        |=> output_code == $past(wdata))
        else $error("direct write did not load the output code");
    a_guard_hold: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R2]
        (is_write && protect && cmd == OFS_OUTPUT_CODE && boot_cnt == STRAP_SETTLE)
        |=> output_code == $past(output_code) && pend_valid)
        else $error("guarded write changed the code before commit");
    a_commit_apply: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R2]
        (is_commit && protect && pend_valid && pend_addr == OFS_OUTPUT_CODE
         && boot_cnt == STRAP_SETTLE) |=> output_code == $past(pend_data) && !pend_valid)
        else $error("commit did not apply the pending write");
    a_loop_level: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R9]
        (loop_hold && !tout_ovr) |=> dac_code_o == {FAULT_LEVEL_LOW, FAULT_LOW_BYTE})
        else $error("loop fault did not drive the low level");
    a_code_pass: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R10]
        (!loop_hold && !tout_ovr) |=> dac_code_o == $past(output_code))
        else $error("output did not follow the code");
    a_mask_release: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R10]
        loop_mask |=> !loop_hold)
        else $error("masked loop fault still holds the output");
    a_retry_none: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R8]
        (loop_hold && retry_dis && !loop_mask && !status_rd) |=> loop_hold)
        else $error("output released with retries disabled");
    a_retry_gap: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R7]
        $rose(loop_hold) && !retry_dis && !loop_mask && !cfg_ld
        |=> (loop_hold && !retry_fire)[*2])
        else $error("retry fired too early");
    a_loop_pin: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R11]
        (loop_flt && !pin_dis) |=> !fault_out_n_o)
        else $error("loop fault did not pull the fault pin");
    a_tout_pin: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R17]
        (!(loop_flt && !pin_dis) && !(tout && !tout_rpt_mask)) |=> fault_out_n_o)
        else $error("fault pin low without a reported fault");
    a_tout_restart: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R14]
        is_write |=> !tout && tout_cyc == 32'h00000000 && tout_ticks == 4'h0)
        else $error("write did not restart the inactivity timer");
    a_tout_level: assert property (@(posedge mclk_i) disable iff (!rst_n) // [R12]
        tout_ovr |=> dac_code_o == lfc_fault_code($past(strap_s2) ? FAULT_LEVEL_HIGH
                                                                  : FAULT_LEVEL_LOW))
        else $error("timeout did not drive the strap fault level");

endmodule : lfc_top
`default_nettype wire

// ---- tb/lfc_spi_master.sv ----
// Serial link master model that sends frames into the register bank
`timescale 1ns/100ps
`default_nettype none
module lfc_spi_master (
    output logic sclk_o,
    output logic chip_select_n_o,
    output logic sdi_o
);
    initial begin
        sclk_o          = 1'b0;
        chip_select_n_o = 1'b1;
        sdi_o           = 1'b0;
    end

    // Clock stands still between frames; idle data flips so no stale bit lingers
    task automatic send(input logic [23:0] word, input int nbits);
        int i;
        chip_select_n_o = 1'b0;
        #17;
        for (i = nbits - 1; i >= 0; i--) begin
            sdi_o  = word[i];
            #15;
            sclk_o = 1'b1;
            #15;
            sclk_o = 1'b0;
        end
        #15;
        chip_select_n_o = 1'b1;
        sdi_o           = ~sdi_o;
        // Gap well above the minimum between frames
        #63;
    endtask : send
endmodule : lfc_spi_master
`default_nettype wire

// ---- tb/loop_dac_fault_config_bench.sv ----
// Self-checking bench for the loop output fault and write-policy registers
`timescale 1ns/100ps
`default_nettype none
module loop_dac_fault_config_bench
    import lfc_pkg::*;
;
    // Short tick keeps timer scenarios within a few thousand cycles
    localparam int TICK = 100;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [15:0] data;
        logic [15:0] code;
    } lfc_row_t;

    logic        mclk;
    logic        rstn;
    logic        sclk;
    logic        csn;
    logic        sdi;
    logic        sdo;
    logic        sdo_oe;
    logic        strap;
    logic        loop_fault;
    logic        fault_n;
    logic [15:0] code;
    int          miscompares = 0;
    int          checks      = 0;
    int          cyc         = 0;
    int          n;
    lfc_row_t    rows [12];

    lfc_top #(.TICK_CYC(TICK)) i_dut (
        .mclk_i                   (mclk),
        .rstn_i                   (rstn),
        .sclk_i                   (sclk),
        .chip_select_n_i          (csn),
        .sdi_i                    (sdi),
        .sdo_o                    (sdo),
        .sdo_oe_o                 (sdo_oe),
        .fault_level_select_pin_i (strap),
        .loop_fault_i             (loop_fault),
        .dac_code_o               (code),
        .fault_out_n_o            (fault_n)
    );

    lfc_spi_master i_master (
        .sclk_o          (sclk),
        .chip_select_n_o (csn),
        .sdi_o           (sdi)
    );

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        i_master.send({c, d}, 24);
        tick(4);
    endtask : wr

    task automatic count_code(input int k);
        n = 0;
        repeat (k) begin
            tick(1);
            if (code === 16'h8001) n++;
        end
    endtask : count_code

    initial begin
        rows = '{
            '{OFS_OUTPUT_CODE,  16'h1234, 16'h1234},
            '{OFS_OUTPUT_CODE,  16'hFFFF, 16'hFFFF},
            '{OFS_NOP,          16'h0000, 16'hFFFF},
            '{8'h84,            16'h0000, 16'hFFFF},
            '{8'h06,            16'hABCD, 16'hFFFF},
            '{OFS_WRITE_POLICY, 16'h0001, 16'hFFFF},
            '{OFS_OUTPUT_CODE,  16'h00A5, 16'hFFFF},
            '{OFS_OUTPUT_CODE,  16'h5A00, 16'hFFFF},
            '{OFS_COMMIT,       COMMIT_KEY, 16'h5A00},
            '{OFS_WRITE_POLICY, 16'h0000, 16'h5A00},
            '{OFS_COMMIT,       COMMIT_KEY, 16'h5A00},
            '{OFS_OUTPUT_CODE,  16'h8001, 16'h8001}
        };
        rstn       = 1'b0;
        strap      = 1'b0;
        loop_fault = 1'b0;
        tick(8);
        rstn = 1'b1;
        tick(10);
        check("reset code low strap", CODE_DEFAULT_LOW, code);
        for (int i = 0; i < 12; i++) begin
            wr(rows[i].cmd, rows[i].data);
            check("row code", rows[i].code, code);
            check("row fault pin", 16'h0001, 16'(fault_n));
            check("row sdo", {15'h0000, rows[i].cmd[7]}, {15'h0000, sdo});
            check("row sdo enable idle", 16'h0000, 16'(sdo_oe));
        end
        tick(150);
        check("pin before expiry", 16'h0001, 16'(fault_n));
        tick(70);
        check("pin after expiry", 16'h0000, 16'(fault_n));
        check("code after expiry", {FAULT_LEVEL_LOW, 8'h00}, code);
        fork
            wr(OFS_NOP, 16'h0000);
            begin
                #100;
                check("sdo enable in frame", 16'h0001, 16'(sdo_oe));
            end
        join
        check("pin after nop", 16'h0001, 16'(fault_n));
        check("code after nop", 16'h8001, code);
        wr(OFS_FAULT_CONFIG, 16'h0010);
        tick(70);
        check("pin short timeout early", 16'h0001, 16'(fault_n));
        tick(40);
        check("pin short timeout", 16'h0000, 16'(fault_n));
        check("code with output mask", 16'h8001, code);
        wr(OFS_FAULT_CONFIG, 16'h0001);
        loop_fault = 1'b1;
        tick(8);
        check("code in loop fault", {FAULT_LEVEL_LOW, 8'h00}, code);
        check("pin in loop fault", 16'h0000, 16'(fault_n));
        count_code(150);
        check("retry count", 16'h0001, 16'(n));
        wr(OFS_FAULT_CONFIG, 16'h0781);
        tick(4);
        count_code(250);
        check("retry disabled count", 16'h0000, 16'(n));
        loop_fault = 1'b0;
        tick(8);
        check("held after fault gone", {FAULT_LEVEL_LOW, 8'h00}, code);
        check("pin after fault gone", 16'h0001, 16'(fault_n));
        wr(8'h89, 16'h0000);
        check("code after status read", 16'h8001, code);
        // Second hold, released through the alternate status address
        loop_fault = 1'b1;
        tick(8);
        loop_fault = 1'b0;
        wr(8'h83, 16'h0000);
        check("held after other read", {FAULT_LEVEL_LOW, 8'h00}, code);
        wr(8'hFF, 16'h0000);
        check("code after alt status read", 16'h8001, code);
        wr(OFS_FAULT_CONFIG, 16'h0041);
        loop_fault = 1'b1;
        tick(8);
        check("code loop masked", 16'h8001, code);
        check("pin loop masked", 16'h0000, 16'(fault_n));
        wr(OFS_FAULT_CONFIG, 16'h0061);
        check("pin disabled", 16'h0001, 16'(fault_n));
        loop_fault = 1'b0;
        // Short frame last: reset below clears any leftover edge count
        i_master.send(24'h04_0000, 23);
        tick(6);
        check("short frame ignored", 16'h8001, code);
        strap = 1'b1;
        rstn  = 1'b0;
        tick(8);
        rstn = 1'b1;
        tick(10);
        check("reset code high strap", CODE_DEFAULT_HIGH, code);
        wr(OFS_OUTPUT_CODE, 16'h1234);
        check("code high strap", 16'h1234, code);
        tick(220);
        check("timeout high level", {FAULT_LEVEL_HIGH, 8'h00}, code);
        check("timeout pin high strap", 16'h0000, 16'(fault_n));
        tally_and_finish();
    end
endmodule : loop_dac_fault_config_bench
`default_nettype wire
